// ---- fawc_cfg.svh ----
// Constants for the flash access wait-state controller
// Overview of operation
// - A page erase ends within 8.0 ms, a page program within 3.5 ms.
// - The control sequence adds a few cycles to each program or erase.
// - A module already addressed by a read is refused new program or erase jobs.
// - Module 4 takes program and erase while any other module is read.
// - Waits apply to non-sequential reads; prefetch serves sequential ones.
// - A cacheable read adds one wait on a miss and has no waits at all on a hit.
// - After power-on every word reads as erased and no protection is active.
`ifndef FAWC_CFG_SVH
`define FAWC_CFG_SVH
`define FAWC_CLK_MHZ        100
`define FAWC_ERASE_TIME_US  7000
`define FAWC_ERASE_MAX_US   8000
`define FAWC_PROG_TIME_US   3000
`define FAWC_PROG_MAX_US    3500
`define FAWC_SM_OVERHEAD    4
`define FAWC_WAIT_DEFAULT   4'h1
`define FAWC_EXT_DEFAULT    2'h0
`define FAWC_WAIT_SAFE      4'hf
`define FAWC_EXT_SAFE       2'h1
`define FAWC_DATA_ERASED    1'b1
`define FAWC_EXEMPT_MODULE  3'h4
`endif

// ---- fawc_pkg.sv ----
// Types for the flash access wait-state controller
`default_nettype none
package fawc_pkg;
   typedef enum logic {FAWC_OP_PROGRAM, FAWC_OP_ERASE} fawc_op_t;
   typedef enum logic [1:0] {FAWC_RD_IDLE, FAWC_RD_WAIT, FAWC_RD_FETCH}
      fawc_rd_state_t;
endpackage : fawc_pkg
`default_nettype wire

// ---- fawc_mem_if.sv ----
// Interface between controller and flash array
`timescale 1ns/1ps
`default_nettype none
interface fawc_mem_if #(parameter int AW = 7, parameter int DW = 16);
   logic          rdEn;
   logic [AW-1:0] rdAddr;
   logic [DW-1:0] rdData;
   logic          wrEn;
   logic [AW-1:0] wrAddr;
   logic [DW-1:0] wrData;
   modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrData, input rdData);
   modport mem  (input rdEn, rdAddr, wrEn, wrAddr, wrData, output rdData);
endinterface : fawc_mem_if
`default_nettype wire

// ---- fawc_flash_mem.sv ----
// Flash array model with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "fawc_cfg.svh"
module fawc_flash_mem #(
   parameter int DEPTH = 80,
   parameter int DW    = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   fawc_mem_if.mem  bus
);
   logic [DW-1:0] array_reg [DEPTH];
   logic [DW-1:0] array_next [DEPTH];
   logic [DW-1:0] rdData_reg;
   logic [DW-1:0] rdData_next;

   assign bus.rdData = rdData_reg;

   always_comb
   begin
      array_next  = array_reg;
      rdData_next = rdData_reg;
      if (bus.wrEn)
      begin
         array_next[bus.wrAddr] = bus.wrData;
      end
      if (bus.rdEn)
      begin
         rdData_next = array_reg[bus.rdAddr];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            array_reg[i] <= {DW{`FAWC_DATA_ERASED}};
         end
         rdData_reg <= {DW{`FAWC_DATA_ERASED}};
      end
      else
      begin
         array_reg  <= array_next;
         rdData_reg <= rdData_next;
      end
   end
endmodule : fawc_flash_mem
`default_nettype wire

// ---- fawc_ctrl.sv ----
// Flash read wait-state, prefetch and program/erase controller
`timescale 1ns/1ps
`default_nettype none
`include "fawc_cfg.svh"
module fawc_ctrl #(
   parameter int MODS   = 5,
   parameter int WORD_W = 4,
   parameter int DW     = 16,
   parameter int ERASE_CYCLES = `FAWC_ERASE_TIME_US * `FAWC_CLK_MHZ,
   parameter int PROG_CYCLES  = `FAWC_PROG_TIME_US * `FAWC_CLK_MHZ
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 appReset,
   input  wire logic                 safeAccessSet,
   input  wire logic                 cfgLoad,
   input  wire logic [3:0]           cfgWaitCount,
   input  wire logic [1:0]           cfgWaitExt,
   input  wire logic                 rdReq,
   input  wire logic [2:0]           rdModule,
   input  wire logic [WORD_W-1:0]    rdWord,
   input  wire logic                 rdCacheable,
   input  wire logic                 rdCacheHit,
   output logic                      rdReady,
   output logic                      rdValid,
   output logic [DW-1:0]             rdData,
   input  wire logic                 peReq,
   input  wire fawc_pkg::fawc_op_t   peOp,
   input  wire logic [2:0]           peModule,
   input  wire logic [WORD_W-1:0]    peWord,
   input  wire logic [DW-1:0]        peData,
   output logic                      peAck,
   output logic                      peRefused,
   output logic                      peDone,
   output logic [MODS-1:0]           peBusy,
   output logic [3:0]                flashWaitCount,
   output logic [1:0]                flashWaitExtension,
   output logic                      safeFlashAccessAfterReset
);
   default clocking assertClk @(posedge clk); endclocking
   default disable iff (!rst_n);
   localparam int AW = 3 + WORD_W;
   localparam int CW = 20;

   fawc_mem_if #(.AW(AW), .DW(DW)) memBus ();

   fawc_flash_mem #(.DEPTH(MODS << WORD_W), .DW(DW)) uMem (
      .clk   (clk),
      .rst_n (rst_n),
      .bus   (memBus)
   );

   function automatic logic [AW-1:0] flatAddr(input logic [2:0] m,
                                              input logic [WORD_W-1:0] w);
      flatAddr = {m, w};
   endfunction : flatAddr

   ////////////////////////////////////////////////////////////////////////
   // Wait configuration and safe access bit
   logic [3:0] waitCount_reg, waitCount_next;
   logic [1:0] waitExt_reg,   waitExt_next;
   logic       safe_reg,      safe_next;

   always_comb
   begin
      waitCount_next = waitCount_reg;
      waitExt_next   = waitExt_reg;
      safe_next      = safe_reg | safeAccessSet;
      if (appReset)
      begin
         // safe bit survives and selects slow defaults
         waitCount_next = safe_reg ? `FAWC_WAIT_SAFE : `FAWC_WAIT_DEFAULT;
         waitExt_next   = safe_reg ? `FAWC_EXT_SAFE  : `FAWC_EXT_DEFAULT;
      end
      else if (cfgLoad)
      begin
         // software owns the minimum per clock rate
         waitCount_next = cfgWaitCount;
         waitExt_next   = cfgWaitExt;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         waitCount_reg <= `FAWC_WAIT_DEFAULT;
         waitExt_reg   <= `FAWC_EXT_DEFAULT;
         safe_reg      <= 1'b0;
      end
      else
      begin
         waitCount_reg <= waitCount_next;
         waitExt_reg   <= waitExt_next;
         safe_reg      <= safe_next;
      end
   end

   assign flashWaitCount            = waitCount_reg;
   assign flashWaitExtension        = waitExt_reg;
   assign safeFlashAccessAfterReset = safe_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read path with prefetch timer
   fawc_pkg::fawc_rd_state_t rdState_reg, rdState_next;
   logic [5:0]    rdCnt_reg,   rdCnt_next;
   logic [5:0]    pfCnt_reg,   pfCnt_next;
   logic [AW-1:0] lastAddr_reg, lastAddr_next;
   logic [AW-1:0] curAddr_reg, curAddr_next;
   logic          lastValid_reg, lastValid_next;
   logic          rdValid_reg, rdValid_next;
   logic          rdReady_reg, rdReady_next;
   logic [2:0]    actMod_reg,  actMod_next;
   logic          actValid_reg, actValid_next;
   logic [5:0]    baseWaits;
   logic          seqHit;
   logic [AW-1:0] reqAddr;

   always_comb
   begin
      baseWaits = {2'h0, waitCount_reg} + {4'h0, waitExt_reg};
      reqAddr   = flatAddr(rdModule, rdWord);
      seqHit    = lastValid_reg && (reqAddr == lastAddr_reg + AW'(1));
      rdState_next   = rdState_reg;
      rdCnt_next     = rdCnt_reg;
      pfCnt_next     = (pfCnt_reg != 6'h0) ? pfCnt_reg - 6'h1 : pfCnt_reg;
      lastAddr_next  = lastAddr_reg;
      lastValid_next = lastValid_reg;
      curAddr_next   = curAddr_reg;
      rdValid_next   = 1'b0;
      rdReady_next   = rdReady_reg;
      actMod_next    = actMod_reg;
      actValid_next  = actValid_reg;
      memBus.rdEn    = 1'b0;
      memBus.rdAddr  = curAddr_reg;
      case (rdState_reg)
         fawc_pkg::FAWC_RD_IDLE:
         begin
            if (rdReq)
            begin
               curAddr_next  = reqAddr;
               actMod_next   = rdModule;
               actValid_next = 1'b1;
               rdReady_next  = 1'b0;
               rdState_next  = fawc_pkg::FAWC_RD_WAIT;
               if (rdCacheable && rdCacheHit)
               begin
                  rdCnt_next = 6'h0;
               end
               else if (rdCacheable)
               begin
                  rdCnt_next = baseWaits + 6'h1;
               end
               else if (seqHit)
               begin
                  // sequential waits only the prefetch remainder
                  rdCnt_next = pfCnt_next;
               end
               else
               begin
                  // full waits on a non-sequential access
                  rdCnt_next = baseWaits;
               end
            end
         end
         fawc_pkg::FAWC_RD_WAIT:
         begin
            if (rdCnt_reg != 6'h0)
            begin
               rdCnt_next = rdCnt_reg - 6'h1;
            end
            else
            begin
               memBus.rdEn    = 1'b1;
               rdValid_next   = 1'b1;
               lastAddr_next  = curAddr_reg;
               lastValid_next = 1'b1;
               // Prefetch of the next word starts now
               pfCnt_next     = baseWaits;
               rdState_next   = fawc_pkg::FAWC_RD_FETCH;
            end
         end
         default:
         begin
            rdReady_next = 1'b1;
            rdState_next = fawc_pkg::FAWC_RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdState_reg   <= fawc_pkg::FAWC_RD_IDLE;
         rdCnt_reg     <= 6'h0;
         pfCnt_reg     <= 6'h0;
         lastAddr_reg  <= '0;
         lastValid_reg <= 1'b0;
         curAddr_reg   <= '0;
         rdValid_reg   <= 1'b0;
         rdReady_reg   <= 1'b1;
         actMod_reg    <= 3'h0;
         actValid_reg  <= 1'b0;
      end
      else
      begin
         rdState_reg   <= rdState_next;
         rdCnt_reg     <= rdCnt_next;
         pfCnt_reg     <= pfCnt_next;
         lastAddr_reg  <= lastAddr_next;
         lastValid_reg <= lastValid_next;
         curAddr_reg   <= curAddr_next;
         rdValid_reg   <= rdValid_next;
         rdReady_reg   <= rdReady_next;
         actMod_reg    <= actMod_next;
         actValid_reg  <= actValid_next;
      end
   end

   assign rdReady = rdReady_reg;
   assign rdValid = rdValid_reg;
   assign rdData  = memBus.rdData;

   ////////////////////////////////////////////////////////////////////////
   // Program and erase jobs, one timer per module
   logic [CW-1:0]     peCnt_reg  [MODS];
   logic [CW-1:0]     peCnt_next [MODS];
   logic [WORD_W-1:0] peWord_reg [MODS];
   logic [WORD_W-1:0] peWord_next[MODS];
   logic [DW-1:0]     peData_reg [MODS];
   logic [DW-1:0]     peData_next[MODS];
   logic [MODS-1:0]   busy_reg,  busy_next;
   logic              ack_reg,   ack_next;
   logic              ref_reg,   ref_next;
   logic              done_reg,  done_next;
   logic              readBlocks;
   logic              granted;

   always_comb
   begin
      peCnt_next    = peCnt_reg;
      peWord_next   = peWord_reg;
      peData_next   = peData_reg;
      busy_next     = busy_reg;
      ack_next      = 1'b0;
      ref_next      = 1'b0;
      done_next     = 1'b0;
      granted       = 1'b0;
      memBus.wrEn   = 1'b0;
      memBus.wrAddr = '0;
      memBus.wrData = '0;
      // the module feeding reads is locked
      // module 4 is only locked when it is itself read
      readBlocks = actValid_reg && (actMod_reg == peModule);
      for (int m = 0; m < MODS; m++)
      begin
         if (busy_reg[m] && peCnt_reg[m] != '0)
         begin
            peCnt_next[m] = peCnt_reg[m] - CW'(1);
         end
         else if (busy_reg[m] && !granted)
         begin
            // One write port; the lowest-numbered finished module writes, higher-numbered ones wait a cycle
            granted       = 1'b1;
            busy_next[m]  = 1'b0;
            done_next     = 1'b1;
            memBus.wrEn   = 1'b1;
            memBus.wrAddr = flatAddr(3'(m), peWord_reg[m]);
            memBus.wrData = peData_reg[m];
         end
      end
      if (peReq)
      begin
         if (readBlocks || peModule >= 3'(MODS) || busy_reg[peModule])
         begin
            ref_next = 1'b1;
         end
         else
         begin
            ack_next = 1'b1;
            busy_next[peModule] = 1'b1;
            peWord_next[peModule] = peWord;
            peCnt_next[peModule] = (peOp == fawc_pkg::FAWC_OP_ERASE)
               ? CW'(ERASE_CYCLES + `FAWC_SM_OVERHEAD)
               : CW'(PROG_CYCLES + `FAWC_SM_OVERHEAD);
            peData_next[peModule] = (peOp == fawc_pkg::FAWC_OP_ERASE)
               ? {DW{`FAWC_DATA_ERASED}} : peData;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int m = 0; m < MODS; m++)
         begin
            peCnt_reg[m]  <= '0;
            peWord_reg[m] <= '0;
            peData_reg[m] <= '0;
         end
         busy_reg <= '0;
         ack_reg  <= 1'b0;
         ref_reg  <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         peCnt_reg  <= peCnt_next;
         peWord_reg <= peWord_next;
         peData_reg <= peData_next;
         busy_reg   <= busy_next;
         ack_reg    <= ack_next;
         ref_reg    <= ref_next;
         done_reg   <= done_next;
      end
   end

   assign peAck     = ack_reg;
   assign peRefused = ref_reg;
   assign peDone    = done_reg;
   assign peBusy    = busy_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_safe_reset_waits: assert property (appReset && safe_reg
      |=> waitCount_reg == `FAWC_WAIT_SAFE)
      else $error("safe waits not restored");
   a_miss_extra_wait: assert property (rdReady && rdReq && rdCacheable
      && !rdCacheHit |=> rdCnt_reg == baseWaits + 6'h1)
      else $error("cache miss wait wrong");
   a_hit_no_wait: assert property (rdReady && rdReq && rdCacheable
      && rdCacheHit |-> ##2 rdValid)
      else $error("cache hit delayed");
   a_nonseq_wait: assert property (rdReady && rdReq && !rdCacheable
      && !seqHit && !cfgLoad && !appReset |=> rdCnt_reg == baseWaits)
      else $error("non-sequential wait wrong");
   a_seq_not_slower: assert property (rdReady && rdReq && seqHit
      && !rdCacheable |=> rdCnt_reg <= baseWaits)
      else $error("sequential read over-waited");
   a_read_lock: assert property (peReq && actValid_reg
      && actMod_reg == peModule |=> peRefused)
      else $error("read module accepted job");
   a_exempt_module: assert property (peReq
      && peModule == `FAWC_EXEMPT_MODULE && !busy_reg[`FAWC_EXEMPT_MODULE]
      && actMod_reg != `FAWC_EXEMPT_MODULE |=> peAck)
      else $error("module 4 job refused");
   a_job_length: assert property (ack_reg
      |-> peCnt_reg[$past(peModule)] <= CW'(`FAWC_CLK_MHZ
      * (($past(peOp) == fawc_pkg::FAWC_OP_ERASE)
      ? `FAWC_ERASE_MAX_US : `FAWC_PROG_MAX_US)))
      else $error("job longer than allowed");
   a_job_overhead: assert property (peReq && !ref_next
      && peOp == fawc_pkg::FAWC_OP_PROGRAM
      |=> peCnt_reg[$past(peModule)] == CW'(PROG_CYCLES + `FAWC_SM_OVERHEAD))
      else $error("program count wrong");
endmodule : fawc_ctrl
`default_nettype wire

// ---- fawc_master_model.sv ----
// Bus master model issuing flash reads and program/erase jobs
`timescale 1ns/1ps
`default_nettype none
module fawc_master_model (
   input  wire logic          clk,
   input  wire logic          rdReady,
   input  wire logic          rdValid,
   input  wire logic [15:0]   rdData,
   input  wire logic          peAck,
   input  wire logic          peRefused,
   input  wire logic          peDone,
   output logic               rdReq,
   output logic [2:0]         rdModule,
   output logic [3:0]         rdWord,
   output logic               rdCacheable,
   output logic               rdCacheHit,
   output logic               peReq,
   output var fawc_pkg::fawc_op_t peOp,
   output logic [2:0]         peModule,
   output logic [3:0]         peWord,
   output logic [15:0]        peData
);
   initial
   begin
      rdReq = 1'b0; rdModule = 3'h0; rdWord = 4'h0;
      rdCacheable = 1'b0; rdCacheHit = 1'b0; peReq = 1'b0;
      peOp = fawc_pkg::FAWC_OP_PROGRAM; peModule = 3'h0; peWord = 4'h0;
      peData = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////
   // Called at a falling edge; lat is the edge that sees rdValid high
   task automatic read_word(input logic [2:0] m, input logic [3:0] w,
      input logic c, input logic h, output logic [15:0] d, output int lat);
      int n;
      n = 0;
      while (rdReady !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      rdReq = 1'b1; rdModule = m; rdWord = w; rdCacheable = c; rdCacheHit = h;
      @(negedge clk);
      // Released address lines show a changed value, not the old one
      rdReq = 1'b0; rdModule = ~m; rdWord = ~w;
      lat = 1;
      while (rdValid !== 1'b1 && lat < 40)
      begin
         @(negedge clk);
         lat++;
      end
      d = rdData;
   endtask : read_word
   ////////////////////////////////////////////////////////////////////////
   // master side: the testbench also aims one job at the read module to see it refused
   task automatic pe_job(input fawc_pkg::fawc_op_t op, input logic [2:0] m,
      input logic [3:0] w, input logic [15:0] dat, input logic waitDone,
      output logic [1:0] resp, output int lat);
      peReq = 1'b1; peOp = op; peModule = m; peWord = w; peData = dat;
      @(negedge clk);
      peReq = 1'b0; peWord = ~w; peData = ~dat;
      lat = 1;
      resp = {peAck, peRefused};
      while (waitDone && resp == 2'b10 && peDone !== 1'b1 && lat < 60)
      begin
         @(negedge clk);
         lat++;
      end
      // An edge passes so a following job never retoggles peReq at once
      @(negedge clk);
   endtask : pe_job
endmodule : fawc_master_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the flash wait-state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int PROG_C  = 10;
   localparam int ERASE_C = 20;
   logic clk, rst_n, appReset, safeAccessSet, cfgLoad;
   logic [3:0] cfgWaitCount, flashWaitCount;
   logic [1:0] cfgWaitExt, flashWaitExtension;
   logic rdReq, rdCacheable, rdCacheHit, rdReady, rdValid, peReq;
   logic peAck, peRefused, peDone, safeFlashAccessAfterReset;
   logic [2:0] rdModule, peModule;
   logic [3:0] rdWord, peWord;
   logic [15:0] rdData, peData, d;
   logic [4:0] peBusy;
   logic [1:0] rs;
   fawc_pkg::fawc_op_t peOp;
   int fail_count = 0, tests_run = 0, lat, k;
   fawc_ctrl #(.ERASE_CYCLES(ERASE_C), .PROG_CYCLES(PROG_C)) u_fawc_ctrl (
      .clk(clk), .rst_n(rst_n), .appReset(appReset),
      .safeAccessSet(safeAccessSet), .cfgLoad(cfgLoad),
      .cfgWaitCount(cfgWaitCount), .cfgWaitExt(cfgWaitExt), .rdReq(rdReq),
      .rdModule(rdModule), .rdWord(rdWord), .rdCacheable(rdCacheable),
      .rdCacheHit(rdCacheHit), .rdReady(rdReady), .rdValid(rdValid),
      .rdData(rdData), .peReq(peReq), .peOp(peOp), .peModule(peModule),
      .peWord(peWord), .peData(peData), .peAck(peAck),
      .peRefused(peRefused), .peDone(peDone), .peBusy(peBusy),
      .flashWaitCount(flashWaitCount),
      .flashWaitExtension(flashWaitExtension),
      .safeFlashAccessAfterReset(safeFlashAccessAfterReset));
   fawc_master_model u_fawc_master_model (
      .clk(clk), .rdReady(rdReady), .rdValid(rdValid), .rdData(rdData),
      .peAck(peAck), .peRefused(peRefused), .peDone(peDone), .rdReq(rdReq),
      .rdModule(rdModule), .rdWord(rdWord), .rdCacheable(rdCacheable),
      .rdCacheHit(rdCacheHit), .peReq(peReq), .peOp(peOp),
      .peModule(peModule), .peWord(peWord), .peData(peData));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic load_cfg(input logic [3:0] c, input logic [1:0] e);
      cfgLoad = 1'b1; cfgWaitCount = c; cfgWaitExt = e;
      @(negedge clk);
      cfgLoad = 1'b0; cfgWaitCount = ~c; cfgWaitExt = ~e;
      @(negedge clk);
   endtask : load_cfg
   task automatic pulse_app();
      appReset = 1'b1;
      @(negedge clk);
      appReset = 1'b0;
      @(negedge clk);
   endtask : pulse_app
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("rdReady", 16'(rdReady), 16'h0001);
      check("rdValid", 16'(rdValid), 16'h0000);
      check("rdData", rdData, 16'hffff);
      check("peBusy", 16'(peBusy), 16'h0000);
      check("waits", 16'({flashWaitCount, flashWaitExtension}), 16'h0004);
      check("safe", 16'(safeFlashAccessAfterReset), 16'h0000);
      $display("Test reset done");
   endtask : t_reset
   task automatic t_reads();
      // base 4 and extension 1 suit a 100 MHz clock
      load_cfg(4'h4, 2'h1);
      check("waits", 16'({flashWaitCount, flashWaitExtension}), 16'h0011);
      u_fawc_master_model.read_word(3'h0, 4'h3, 1'b0, 1'b0, d, lat);
      check("nonseq latency", 16'(lat), 16'h0007);
      check("erased word", d, 16'hffff);
      repeat (10) @(negedge clk);
      u_fawc_master_model.read_word(3'h0, 4'h4, 1'b0, 1'b0, d, lat);
      check("seq latency", 16'(lat), 16'h0002);
      u_fawc_master_model.read_word(3'h2, 4'h0, 1'b1, 1'b0, d, lat);
      check("miss latency", 16'(lat), 16'h0008);
      u_fawc_master_model.read_word(3'h2, 4'h5, 1'b1, 1'b1, d, lat);
      check("hit latency", 16'(lat), 16'h0002);
      $display("Test reads done");
   endtask : t_reads
   task automatic t_pe();
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_PROGRAM, 3'h1, 4'h2,
         16'h1234, 1'b1, rs, lat);
      check("prog resp", 16'(rs), 16'h0002);
      check("prog time", 16'(lat), 16'(PROG_C + 6));
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_PROGRAM, 3'h3, 4'h2,
         16'h00a5, 1'b1, rs, lat);
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_ERASE, 3'h3, 4'h2,
         16'h0000, 1'b1, rs, lat);
      check("erase time", 16'(lat), 16'(ERASE_C + 6));
      u_fawc_master_model.read_word(3'h3, 4'h2, 1'b0, 1'b0, d, lat);
      check("erased data", d, 16'hffff);
      u_fawc_master_model.read_word(3'h1, 4'h2, 1'b0, 1'b0, d, lat);
      check("programmed data", d, 16'h1234);
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_PROGRAM, 3'h1, 4'h0,
         16'h0001, 1'b1, rs, lat);
      check("read module job", 16'(rs), 16'h0001);
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_ERASE, 3'h5, 4'h0,
         16'h0000, 1'b1, rs, lat);
      check("bad module job", 16'(rs), 16'h0001);
      // only one job runs in parallel here
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_PROGRAM, 3'h4, 4'h0,
         16'h5a5a, 1'b0, rs, lat);
      check("module four job", 16'(rs), 16'h0002);
      check("busy flags", 16'(peBusy), 16'h0010);
      u_fawc_master_model.pe_job(fawc_pkg::FAWC_OP_PROGRAM, 3'h4, 4'h1,
         16'h0000, 1'b0, rs, lat);
      check("busy module job", 16'(rs), 16'h0001);
      k = 0;
      while (peDone !== 1'b1 && k < 40)
      begin
         @(negedge clk);
         k++;
      end
      check("job done", 16'(peDone), 16'h0001);
      @(negedge clk);
      check("busy cleared", 16'(peBusy), 16'h0000);
      $display("Test program erase done");
   endtask : t_pe
   task automatic t_app();
      pulse_app();
      check("app waits", 16'({flashWaitCount, flashWaitExtension}),
         16'h0004);
      // safe bit set before a fast clock
      safeAccessSet = 1'b1;
      @(negedge clk);
      safeAccessSet = 1'b0;
      pulse_app();
      check("safe bit", 16'(safeFlashAccessAfterReset), 16'h0001);
      check("safe waits", 16'({flashWaitCount, flashWaitExtension}),
         16'h003d);
      u_fawc_master_model.read_word(3'h0, 4'h9, 1'b0, 1'b0, d, lat);
      check("safe latency", 16'(lat), 16'h0012);
      $display("Test application reset done");
   endtask : t_app
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   initial
   begin
      rst_n = 1'b0; appReset = 1'b0; safeAccessSet = 1'b0; cfgLoad = 1'b0;
      cfgWaitCount = 4'h0; cfgWaitExt = 2'h0;
      repeat (20) @(negedge clk);
      t_reset();
      rst_n = 1'b1;
      @(negedge clk);
      t_reads();
      t_pe();
      t_app();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
